//--- verilog/xbr_defs.svh
// timing counts and command codes for the cross-bank command rules
`ifndef XBR_DEFS_SVH
`define XBR_DEFS_SVH
`define XBR_CLK_MHZ 25
`define XBR_T_RP_NS 18
`define XBR_T_RCD_NS 18
`define XBR_T_WR_NS 15
`define XBR_T_XP_NS 25
`define XBR_RP_CYC ((`XBR_T_RP_NS * `XBR_CLK_MHZ + 999) / 1000)
`define XBR_RCD_CYC ((`XBR_T_RCD_NS * `XBR_CLK_MHZ + 999) / 1000)
`define XBR_WR_CYC ((`XBR_T_WR_NS * `XBR_CLK_MHZ + 999) / 1000)
`define XBR_XP_CYC ((`XBR_T_XP_NS * `XBR_CLK_MHZ + 999) / 1000)
`define XBR_CL 3
`define XBR_BL 4
`define XBR_CMD_NOP 4'h7
`define XBR_CMD_ACT 4'h3
`define XBR_CMD_RD 4'h5
`define XBR_CMD_WR 4'h4
`define XBR_CMD_PRE 4'h2
`define XBR_CMD_BST 4'h6
`define XBR_CMD_REF 4'h1
`define XBR_CMD_MRS 4'h0
`define XBR_CMD_DESEL 4'h8
`endif

//--- verilog/xbr_pkg.sv
// types shared by both ends of the cross-bank command link
package xbr_pkg;
	typedef enum logic [2:0] {
		XBR_IDLE, XBR_ACTIVATING, XBR_ACTIVE, XBR_READ, XBR_WRITE,
		XBR_AC_ACCESS, XBR_AC_PRECH, XBR_PRECHARGING
	} xbr_bank_e;
	typedef struct packed {
		xbr_bank_e st;
		logic [3:0] cnt;
		logic is_wr;
	} xbr_bank_s;
endpackage

//--- verilog/xbr_if.sv
// command link between controller and device
`timescale 1ns/100ps
`default_nettype none
interface xbr_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic a10;
	logic [3:0] write_byte_mask;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, a10, write_byte_mask);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, a10, write_byte_mask);
endinterface
`default_nettype wire

//--- verilog/xbr_bank.sv
// one bank state tracker
`timescale 1ns/100ps
`default_nettype none
`include "xbr_defs.svh"
module xbr_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic valid,
	input wire logic [3:0] cmd,
	input wire logic hit,
	input wire logic auto_close_option,
	input wire logic bst_hit,
	output var xbr_pkg::xbr_bank_s q
);
	localparam logic [3:0] RP = 4'(`XBR_RP_CYC);
	localparam logic [3:0] RCD = 4'(`XBR_RCD_CYC);
	localparam logic [3:0] RD_END = 4'(`XBR_BL / 2);
	localparam logic [3:0] WR_END = 4'(`XBR_BL / 2 + `XBR_WR_CYC);
	xbr_pkg::xbr_bank_s next_q;
	always_comb begin
		next_q = q;
		if (q.cnt != 4'h0) begin
			next_q.cnt = q.cnt - 4'h1;
		end
		case (q.st)
			xbr_pkg::XBR_PRECHARGING: if (q.cnt <= 4'h1) next_q.st = xbr_pkg::XBR_IDLE;
			xbr_pkg::XBR_ACTIVATING: if (q.cnt <= 4'h1) next_q.st = xbr_pkg::XBR_ACTIVE;
			xbr_pkg::XBR_READ, xbr_pkg::XBR_WRITE: begin
				if (q.cnt <= 4'h1 || bst_hit) begin
					next_q.st = xbr_pkg::XBR_ACTIVE;
					next_q.cnt = 4'h0;
				end
			end
			xbr_pkg::XBR_AC_ACCESS: begin
				if (q.cnt <= 4'h1) begin
					next_q.st = xbr_pkg::XBR_AC_PRECH;
					next_q.cnt = RP;
				end
			end
			xbr_pkg::XBR_AC_PRECH: if (q.cnt <= 4'h1) next_q.st = xbr_pkg::XBR_IDLE;
			default: ;
		endcase
		// nop and deselect fall to the default branch here, so running bursts continue
		if (valid && hit) begin
			case (cmd)
				`XBR_CMD_ACT: begin
					next_q.st = xbr_pkg::XBR_ACTIVATING;
					next_q.cnt = RCD;
				end
				`XBR_CMD_PRE: begin
					next_q.st = xbr_pkg::XBR_PRECHARGING;
					next_q.cnt = RP;
				end
				`XBR_CMD_RD, `XBR_CMD_WR: begin
					next_q.is_wr = (cmd == `XBR_CMD_WR);
					next_q.cnt = (cmd == `XBR_CMD_WR) ? WR_END : RD_END;
					if (auto_close_option) begin
						next_q.st = xbr_pkg::XBR_AC_ACCESS;
					end else begin
						next_q.st = (cmd == `XBR_CMD_WR) ? xbr_pkg::XBR_WRITE : xbr_pkg::XBR_READ;
						next_q.cnt = RD_END;
					end
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{st: xbr_pkg::XBR_IDLE, cnt: 4'h0, is_wr: 1'b0};
		end else begin
			q <= next_q;
		end
	end
endmodule
`default_nettype wire

//--- verilog/xbr_dev.sv
// device end: samples pins and tracks the four banks
`timescale 1ns/100ps
`default_nettype none
`include "xbr_defs.svh"
module xbr_dev #(
	parameter int NBANK = 4
) (
	input wire logic clk,
	input wire logic rst,
	xbr_if.dev link,
	output logic [4*NBANK-1:0] bank_state,
	output logic all_idle,
	output logic cmd_seen
);
	initial begin
		if (NBANK != 4) $error("xbr_dev serves four banks only");
	end
	typedef struct packed {
		logic cke_prev;
		logic [3:0] cmd;
		logic [1:0] ba;
		logic a10;
		logic valid;
		logic [NBANK*4-1:0] bstate;
		logic idle;
		logic seen;
		logic [1:0] last_rd;
	} xbr_dev_s;
	xbr_dev_s s;
	xbr_dev_s next_s;
	xbr_pkg::xbr_bank_s bq [NBANK];
	logic [3:0] pin_cmd;
	assign pin_cmd = link.cs_n ? `XBR_CMD_DESEL : {1'b0, link.ras_n, link.cas_n, link.we_n};
	genvar g;
	generate
		for (g = 0; g < NBANK; g++) begin : bank
			xbr_bank u_bank (
				.clk(clk),
				.rst(rst),
				.valid(s.valid),
				.cmd(s.cmd),
				.hit(s.ba == 2'(g) || (s.cmd == `XBR_CMD_PRE && s.a10)),
				.auto_close_option(s.a10),
				.bst_hit(s.valid && s.cmd == `XBR_CMD_BST && s.last_rd == 2'(g)),
				.q(bq[g])
			);
		end
	endgenerate
	always_comb begin
		next_s = s;
		next_s.cke_prev = link.cke;
		next_s.cmd = pin_cmd;
		next_s.ba = link.ba;
		next_s.a10 = link.a10;
		next_s.valid = s.cke_prev && link.cke && !link.cs_n;
		next_s.seen = next_s.valid;
		if (s.valid && s.cmd == `XBR_CMD_RD) begin
			next_s.last_rd = s.ba;
		end
		next_s.idle = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			next_s.bstate[i*4 +: 4] = {1'b0, bq[i].st};
			if (bq[i].st != xbr_pkg::XBR_IDLE) next_s.idle = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign bank_state = s.bstate;
	assign all_idle = s.idle;
	assign cmd_seen = s.seen;
endmodule
`default_nettype wire

//--- verilog/xbr_ctrl.sv
// controller end: checks each request against all bank states before issue
`timescale 1ns/100ps
`default_nettype none
`include "xbr_defs.svh"
// ==========================================
// Functional notes
// - commands only with cke high twice, after exit
// - deselect and nop behave the same
// - never issue an unlisted combination
// - idle only after full precharge period
// - row active after activate delay, no burst
// - read or write state until burst ends
// - auto-close read precharge at earliest precharge point
// - auto-close write precharge after write recovery
// - access portion lasts until precharge portion
// - precharge portion allows act pre rd wr elsewhere
// - access portion allows only act pre elsewhere
// - honour timing, no read write data collision
// - refresh and mode set only all idle
// - burst terminate only to its own bank
// - permissions cover both auto-close settings
// - mask remaining write data on read interrupt
// - write after read only when output done
// - precharging until precharge period elapses then idle
// - read is cs low ras high cas low we high
module xbr_ctrl #(
	parameter int NBANK = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [3:0] req_cmd,
	input wire logic [1:0] req_bank,
	input wire logic req_auto_close,
	output logic req_ready,
	output logic req_taken,
	xbr_if.ctrl link
);
	initial begin
		if (NBANK != 4) $error("xbr_ctrl serves four banks only");
	end
	localparam logic [3:0] XP = 4'(`XBR_XP_CYC);
	localparam logic [3:0] RD_DONE = 4'(`XBR_CL + `XBR_BL / 2);
	typedef struct packed {
		logic cke;
		logic [3:0] xp_cnt;
		logic [3:0] rd_out;
		logic [1:0] last_rd;
		logic [3:0] cmd;
		logic [1:0] ba;
		logic a10;
		logic [3:0] mask;
		logic taken;
		logic ready;
	} xbr_ctrl_s;
	xbr_ctrl_s s;
	xbr_ctrl_s next_s;
	xbr_pkg::xbr_bank_s bq [NBANK];
	logic ok;
	logic any_wr;
	genvar g;
	generate
		for (g = 0; g < NBANK; g++) begin : bank
			xbr_bank u_bank (
				.clk(clk),
				.rst(rst),
				.valid(s.cmd != `XBR_CMD_DESEL && s.cmd != `XBR_CMD_NOP),
				.cmd(s.cmd),
				.hit(s.ba == 2'(g) || (s.cmd == `XBR_CMD_PRE && s.a10)),
				.auto_close_option(s.a10),
				.bst_hit(s.cmd == `XBR_CMD_BST && s.last_rd == 2'(g)),
				.q(bq[g])
			);
		end
	endgenerate
	always_comb begin
		ok = (s.xp_cnt == 4'h0) && s.cke;
		any_wr = 1'b0;
		for (int i = 0; i < NBANK; i++) begin
			if (bq[i].st == xbr_pkg::XBR_WRITE
					|| (bq[i].st == xbr_pkg::XBR_AC_ACCESS && bq[i].is_wr)) any_wr = 1'b1;
			if (2'(i) == req_bank) begin
				case (req_cmd)
					`XBR_CMD_ACT: if (bq[i].st != xbr_pkg::XBR_IDLE) ok = 1'b0;
					`XBR_CMD_RD, `XBR_CMD_WR: begin
						if (bq[i].st != xbr_pkg::XBR_ACTIVE && bq[i].st != xbr_pkg::XBR_READ
								&& bq[i].st != xbr_pkg::XBR_WRITE) ok = 1'b0;
					end
					`XBR_CMD_PRE: begin
						if (bq[i].st == xbr_pkg::XBR_ACTIVATING
								|| bq[i].st == xbr_pkg::XBR_AC_ACCESS
								|| bq[i].st == xbr_pkg::XBR_AC_PRECH) ok = 1'b0;
					end
					`XBR_CMD_BST: if (bq[i].st != xbr_pkg::XBR_READ || s.last_rd != req_bank) ok = 1'b0;
					default: ;
				endcase
			end else begin
				case (bq[i].st)
					xbr_pkg::XBR_AC_ACCESS: begin
						if (req_cmd != `XBR_CMD_ACT && req_cmd != `XBR_CMD_PRE) ok = 1'b0;
					end
					xbr_pkg::XBR_AC_PRECH: ;
					default: ;
				endcase
			end
			if ((req_cmd == `XBR_CMD_REF || req_cmd == `XBR_CMD_MRS)
					&& bq[i].st != xbr_pkg::XBR_IDLE) ok = 1'b0;
		end
		if (req_cmd == `XBR_CMD_WR && s.rd_out != 4'h0) ok = 1'b0;
		if (req_cmd == `XBR_CMD_NOP || req_cmd == `XBR_CMD_DESEL) ok = 1'b0;
		// trackers see an issued command one cycle late, so hold off one cycle
		if (s.taken) ok = 1'b0;
		next_s = s;
		next_s.cke = 1'b1;
		if (!s.cke) next_s.xp_cnt = XP;
		else if (s.xp_cnt != 4'h0) next_s.xp_cnt = s.xp_cnt - 4'h1;
		if (s.rd_out != 4'h0) next_s.rd_out = s.rd_out - 4'h1;
		if (s.cmd == `XBR_CMD_RD) next_s.last_rd = s.ba;
		next_s.cmd = `XBR_CMD_NOP;
		next_s.ba = 2'h0;
		next_s.a10 = 1'b0;
		next_s.mask = 4'h0;
		next_s.taken = 1'b0;
		next_s.ready = ok;
		if (req_valid && ok) begin
			next_s.cmd = req_cmd;
			next_s.ba = req_bank;
			next_s.a10 = req_auto_close;
			next_s.taken = 1'b1;
			if (req_cmd == `XBR_CMD_RD) begin
				next_s.rd_out = RD_DONE;
				if (any_wr) next_s.mask = 4'hF;
			end
			if (req_cmd == `XBR_CMD_BST) next_s.rd_out = 4'h0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '{cke: 1'b0, xp_cnt: 4'h0, rd_out: 4'h0, last_rd: 2'h0, cmd: `XBR_CMD_NOP,
				ba: 2'h0, a10: 1'b0, mask: 4'h0, taken: 1'b0, ready: 1'b0};
		end else begin
			s <= next_s;
		end
	end
	// read encoding cs low ras high cas low we high; deselect drives cs high
	assign link.cs_n = s.cmd[3];
	assign link.ras_n = s.cmd[2];
	assign link.cas_n = s.cmd[1];
	assign link.we_n = s.cmd[0];
	assign link.cke = s.cke;
	assign link.ba = s.ba;
	assign link.a10 = s.a10;
	assign link.write_byte_mask = s.mask;
	assign req_ready = s.ready;
	assign req_taken = s.taken;
endmodule
`default_nettype wire

//--- tb/xbr_assertions.sv
// concurrent checks on the command link between the two ends
`timescale 1ns/100ps
`default_nettype none
`include "xbr_defs.svh"
module xbr_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic a10,
	input wire logic [3:0] write_byte_mask
);
	localparam int RDGAP = `XBR_CL + `XBR_BL / 2;
	logic [3:0] c;
	logic rw;
	logic [3:0] open;
	logic [2:0] acc;
	logic [3:0] since;
	assign c = {cs_n, ras_n, cas_n, we_n};
	assign rw = c == `XBR_CMD_RD || c == `XBR_CMD_WR;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================
	// shadow of open rows and auto-close windows
	// acc is loaded one short: it counts cycles still left after the issue edge
	always_ff @(posedge clk) begin
		if (rst) begin
			open <= 4'h0;
			acc <= 3'h0;
			since <= 4'hF;
		end else begin
			since <= (c == `XBR_CMD_RD) ? 4'h1 : ((since == 4'hF) ? since : since + 4'h1);
			if (rw && a10) begin
				acc <= (c == `XBR_CMD_RD) ? 3'(`XBR_BL / 2 - 1) : 3'(`XBR_BL / 2 + `XBR_WR_CYC - 1);
			end else begin
				acc <= (acc != 3'h0) ? acc - 3'h1 : 3'h0;
			end
			if (c == `XBR_CMD_ACT) begin
				open[ba] <= 1'b1;
			end else if (c == `XBR_CMD_PRE && a10) begin
				open <= 4'h0;
			end else if (c == `XBR_CMD_PRE || (rw && a10)) begin
				open[ba] <= 1'b0;
			end
		end
	end
	// ==========================================
	// checks
	reset_nop_a: assert property ($past(rst) |-> !cke && c == `XBR_CMD_NOP)
		else $error("link not idle after reset");
	cke_rise_a: assert property ($past(rst) |=> cke)
		else $error("clock enable not raised");
	cke_hold_a: assert property (cke |=> cke)
		else $error("clock enable dropped");
	cmd_cke_a: assert property (!c[3] && c != `XBR_CMD_NOP |-> cke && $past(cke))
		else $error("command without clock enable");
	ref_idle_a: assert property (c == `XBR_CMD_REF || c == `XBR_CMD_MRS |-> open == 4'h0)
		else $error("refresh or mode set with open row");
	rw_open_a: assert property (rw |-> open[ba])
		else $error("access to closed bank");
	act_closed_a: assert property (c == `XBR_CMD_ACT |-> !open[ba])
		else $error("activate to open bank");
	wr_gap_a: assert property (c == `XBR_CMD_WR |-> since >= 4'(RDGAP))
		else $error("write during read output");
	ac_access_a: assert property (rw |-> acc == 3'h0)
		else $error("access during auto-close access");
	mask_read_a: assert property (write_byte_mask != 4'h0 |-> c == `XBR_CMD_RD)
		else $error("write mask outside read issue");
	cover property (c == `XBR_CMD_ACT);
	cover property (rw && a10);
	cover property (c == `XBR_CMD_REF);
	cover property (c == `XBR_CMD_WR && since != 4'hF);
	cover property (write_byte_mask == 4'hF);
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for controller and device ends
`timescale 1ns/100ps
`default_nettype none
`include "xbr_defs.svh"
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic [3:0] req_cmd = `XBR_CMD_NOP;
	logic [1:0] req_bank = 2'h0;
	logic req_auto_close = 1'b0;
	logic req_ready;
	logic req_taken;
	logic [15:0] bank_state;
	logic all_idle;
	logic cmd_seen;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 32'hB008;
	logic [6:0] notes[$];
	xbr_if link ();
	xbr_ctrl xbr_ctrl_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_bank(req_bank), .req_auto_close(req_auto_close), .req_ready(req_ready),
		.req_taken(req_taken), .link(link));
	xbr_dev xbr_dev_inst (.clk(clk), .rst(rst), .link(link), .bank_state(bank_state),
		.all_idle(all_idle), .cmd_seen(cmd_seen));
	xbr_assertions xbr_assertions_inst (.clk(clk), .rst(rst), .cke(link.cke),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.ba(link.ba), .a10(link.a10), .write_byte_mask(link.write_byte_mask));
	initial begin
		forever #20 clk = ~clk;
	end
	// ==========================================
	// tasks
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// refused requests are retried in single pulses so a late take is never doubled
	task automatic send(input logic [3:0] c, input logic [1:0] b, input logic ac, input bit ok);
		int n;
		req_cmd = c;
		req_bank = b;
		req_auto_close = ac;
		if (ok) notes.push_back({c, b, ac});
		for (n = 0; n < (ok ? 30 : 4); n++) begin
			req_valid = 1'b1;
			@(posedge clk);
			#1;
			req_valid = 1'b0;
			if (req_taken === 1'b1) break;
			@(posedge clk);
			#1;
		end
		if (ok && n == 30) chk("taken", 4'h1, 4'h0);
	endtask
	task automatic wait_st(input logic [1:0] b, input xbr_pkg::xbr_bank_e s);
		int n;
		for (n = 0; n < 40 && bank_state[4*b+:3] !== s; n++) begin
			@(posedge clk);
			#1;
		end
		chk("state", {1'b0, s}, {1'b0, bank_state[4*b+:3]});
	endtask
	// ==========================================
	// watcher: every issued command must match the oldest note
	always @(negedge clk) begin
		logic [6:0] e;
		if (!rst && req_taken === 1'b1) begin
			e = (notes.size() != 0) ? notes.pop_front() : 7'h7F;
			chk("command", e[6:3], {link.cs_n, link.ras_n, link.cas_n, link.we_n});
			chk("bank", {2'h0, e[2:1]}, {2'h0, link.ba});
			if (e[6:3] inside {`XBR_CMD_RD, `XBR_CMD_WR, `XBR_CMD_PRE}) begin
				chk("a10", {3'h0, e[0]}, {3'h0, link.a10});
			end
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		int i;
		logic [1:0] b;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("all_idle", 4'h1, {3'h0, all_idle});
		for (i = 0; i < 4; i++) wait_st(i[1:0], xbr_pkg::XBR_IDLE);
		send(`XBR_CMD_NOP, 2'h0, 1'b0, 1'b0);
		send(`XBR_CMD_DESEL, 2'h1, 1'b0, 1'b0);
		send(`XBR_CMD_REF, 2'h0, 1'b0, 1'b1);
		send(`XBR_CMD_MRS, 2'h0, 1'b0, 1'b1);
		send(`XBR_CMD_ACT, 2'h0, 1'b0, 1'b1);
		wait_st(2'h0, xbr_pkg::XBR_ACTIVE);
		send(`XBR_CMD_REF, 2'h0, 1'b0, 1'b0);
		send(`XBR_CMD_MRS, 2'h0, 1'b0, 1'b0);
		send(`XBR_CMD_RD, 2'h0, 1'b0, 1'b1);
		wait_st(2'h0, xbr_pkg::XBR_READ);
		wait_st(2'h0, xbr_pkg::XBR_ACTIVE);
		send(`XBR_CMD_ACT, 2'h1, 1'b0, 1'b1);
		send(`XBR_CMD_RD, 2'h0, 1'b1, 1'b1);
		wait_st(2'h0, xbr_pkg::XBR_AC_ACCESS);
		send(`XBR_CMD_RD, 2'h1, 1'b0, 1'b1);
		wait_st(2'h0, xbr_pkg::XBR_IDLE);
		send(`XBR_CMD_WR, 2'h1, 1'b1, 1'b1);
		wait_st(2'h1, xbr_pkg::XBR_IDLE);
		for (i = 0; i < 6; i++) begin
			b = 2'($random(seed));
			send(`XBR_CMD_ACT, b, 1'b0, 1'b1);
			send(`XBR_CMD_PRE, b, 1'b0, 1'b1);
			wait_st(b, xbr_pkg::XBR_IDLE);
		end
		chk("all_idle", 4'h1, {3'h0, all_idle});
		print_verdict();
	end
endmodule
`default_nettype wire
